// ---- hdl/rtc_date_trim_pkg.sv ----
// package: register map, field layouts, reset values and timing counts
package rtc_date_trim_pkg;
    localparam logic [3:0] addr_day = 4'h4;
    localparam logic [3:0] addr_month = 4'h5;
    localparam logic [3:0] addr_year = 4'h6;
    localparam logic [3:0] addr_trim = 4'h7;
    localparam logic [3:0] addr_alarm_a_min = 4'h8;
    localparam logic [3:0] addr_alarm_b_min = 4'hb;
    localparam logic [7:0] mask_day = 8'h3f;
    localparam logic [7:0] mask_month = 8'h1f;
    localparam logic [7:0] mask_year = 8'hff;
    localparam logic [7:0] mask_alarm_min = 8'h7f;
    localparam logic [7:0] reset_day = 8'h01;
    localparam logic [7:0] reset_month = 8'h01;
    localparam logic [7:0] reset_year = 8'h00;
    localparam logic [7:0] reset_trim = 8'h00;
    localparam logic [7:0] reset_alarm_min = 8'h00;
    localparam int crystal_select_bit = 7;
    localparam int trim_direction_bit = 6;
    localparam logic [15:0] pulses_32768 = 16'h8000;
    localparam logic [15:0] pulses_32000 = 16'h7d00;
    localparam logic [7:0] trim_sec_00 = 8'h00;
    localparam logic [7:0] trim_sec_20 = 8'h20;
    localparam logic [7:0] trim_sec_40 = 8'h40;

    // register access from the host-side logic
    typedef struct packed {
        logic wr_en;
        logic [3:0] addr;
        logic [7:0] wr_data;
    } reg_req_t;

    // calendar state carried together
    typedef struct packed {
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
    } date_t;
endpackage

// ---- hdl/rtc_date_trim_alarm_minute.sv ----
// calendar, time trimming and alarm minute registers of the real-time clock
// How it works
// R1 - day BCD at 4h, D7..D6 read zero
// R2 - month BCD at 5h, D7..D5 read zero
// R3 - year BCD at 6h, all eight bits
// R4 - after halt, trim reads all zeros
// R5 - trim D7 selects 32.768 or 32.000 kHz
// R6 - trim only in seconds 00, 20, 40
// R7 - second every 32768 or 32000 pulses
// R8 - direction zero: lengthen by 2*(mag-1)
// R9 - direction one: shorten by 2*(~mag+1)
// R10 - mag bits 5..1 zero: no change
// R11 - clock output stays uncorrected
// R12 - alarm A at 8h-Ah, B at Bh-Dh
// R13 - alarm A minute at 8h, D7 zero
// R14 - alarm B minute at Bh, D7 zero
// R15 - halt flag clears selector and trim bits
// R16 - day wraps by month length, leap years
// R17 - unused high bits ignored, read zero
module rtc_date_trim_alarm_minute (
    input wire logic ref_clk,
    input wire logic rst,
    input wire rtc_date_trim_pkg::reg_req_t reg_req,
    input wire logic osc_tick,
    input wire logic [7:0] seconds_bcd,
    input wire logic day_carry,
    input wire logic osc_halt_flag,
    output logic [7:0] rd_data,
    output logic second_tick,
    output logic clk32_out,
    output logic [7:0] alarm_a_minute,
    output logic [7:0] alarm_b_minute
);
    // next value of a BCD pair, wrapping from top back to low
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top, input logic [7:0] low);
        logic [7:0] r;
        r = v;
        if (v == top) begin
            r = low;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // year divisible by four, 00 included
    function automatic logic is_leap(input logic [7:0] y);
        logic ok;
        ok = 1'b0;
        if (!y[4]) begin
            ok = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            ok = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return ok;
    endfunction

    // last day of the month in BCD
    function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] d;
        d = 8'h31;
        case (m)
            8'h02: d = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
            default: d = 8'h31;
        endcase
        return d;
    endfunction

    rtc_date_trim_pkg::date_t date_r, date_nxt;
    logic [7:0] trim_r, trim_nxt;
    logic [7:0] alarm_a_r, alarm_a_nxt;
    logic [7:0] alarm_b_r, alarm_b_nxt;
    logic [15:0] pulse_cnt_r, pulse_cnt_nxt;
    logic [7:0] rd_data_nxt;
    logic second_tick_nxt;
    logic [15:0] base_len;
    logic [15:0] second_len;
    logic [5:0] trim_magnitude;
    logic trim_direction;
    logic crystal_select;
    logic trim_second;
    logic trim_active;
    logic wr_day, wr_month, wr_year;
    logic wr_trim;
    logic wr_alarm_a;
    logic wr_alarm_b;
    logic month_end;
    logic year_end;
    logic pulse_last;
    logic [15:0] trim_delta;
    logic clk32_nxt;
    logic [7:0] alarm_a_out_nxt;
    logic [7:0] alarm_b_out_nxt;

    // true when a host write targets the given register
    function automatic logic write_hit(input rtc_date_trim_pkg::reg_req_t req, input logic [3:0] target);
        logic hit;
        hit = 1'b0;
        if (req.wr_en) begin
            hit = (req.addr == target);
        end
        return hit;
    endfunction

    // trim register fields
    assign crystal_select = trim_r[rtc_date_trim_pkg::crystal_select_bit];
    assign trim_direction = trim_r[rtc_date_trim_pkg::trim_direction_bit];
    assign trim_magnitude = trim_r[5:0];

    // one write strobe per mapped register; unmapped addresses hit nothing
    assign wr_day = write_hit(reg_req, rtc_date_trim_pkg::addr_day); // R1
    assign wr_month = write_hit(reg_req, rtc_date_trim_pkg::addr_month); // R2
    assign wr_year = write_hit(reg_req, rtc_date_trim_pkg::addr_year); // R3
    assign wr_trim = write_hit(reg_req, rtc_date_trim_pkg::addr_trim); // R5
    assign wr_alarm_a = write_hit(reg_req, rtc_date_trim_pkg::addr_alarm_a_min); // R12 R13
    assign wr_alarm_b = write_hit(reg_req, rtc_date_trim_pkg::addr_alarm_b_min); // R12 R14

    // pulses added or removed in a trimmed second, always even
    always_comb begin
        trim_delta = 16'h0000;
        if (!trim_direction) begin
            trim_delta = {9'h000, trim_magnitude - 6'h01, 1'b0}; // R8
        end else begin
            trim_delta = {9'h000, (~trim_magnitude) + 6'h01, 1'b0}; // R9
        end
    end

    // length of the current second in oscillator pulses
    always_comb begin
        base_len = crystal_select ? rtc_date_trim_pkg::pulses_32000 : rtc_date_trim_pkg::pulses_32768; // R5 R7
        trim_second = (seconds_bcd == rtc_date_trim_pkg::trim_sec_00)
                   || (seconds_bcd == rtc_date_trim_pkg::trim_sec_20)
                   || (seconds_bcd == rtc_date_trim_pkg::trim_sec_40); // R6
        trim_active = trim_second && (trim_magnitude[5:1] != 5'h00); // R10
        second_len = base_len;
        if (trim_active && !trim_direction) begin
            second_len = base_len + trim_delta; // R8
        end else if (trim_active) begin
            second_len = base_len - trim_delta; // R9
        end
    end

    // last pulse of the current second; >= also ends a second cut short by a new trim
    always_comb begin
        pulse_last = osc_tick && (pulse_cnt_r >= second_len - 16'h0001); // R7
    end

    // divider counting oscillator pulses into seconds
    always_comb begin
        pulse_cnt_nxt = pulse_cnt_r;
        second_tick_nxt = 1'b0;
        if (pulse_last) begin
            pulse_cnt_nxt = 16'h0000;
            second_tick_nxt = 1'b1; // R7
        end else if (osc_tick) begin
            pulse_cnt_nxt = pulse_cnt_r + 16'h0001;
        end
    end

    // divider registers; a fresh second starts after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulse_cnt_r <= 16'h0000;
            second_tick <= 1'b0;
        end else begin
            pulse_cnt_r <= pulse_cnt_nxt;
            second_tick <= second_tick_nxt;
        end
    end

    // clock output follows the raw oscillator pulse, never the trimmed count
    always_comb begin
        clk32_nxt = osc_tick; // R11
    end

    // clock output register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk32_out <= 1'b0;
        end else begin
            clk32_out <= clk32_nxt;
        end
    end

    // end of month and end of year seen by the midnight carry
    always_comb begin
        month_end = date_r.day >= month_last(date_r.month, date_r.year); // R16
        year_end = month_end && (date_r.month >= 8'h12);
    end

    // calendar carry and register writes; a host write wins over the carry
    always_comb begin
        date_nxt = date_r;
        if (day_carry) begin
            if (month_end) begin
                date_nxt.day = 8'h01; // R16
                date_nxt.month = bcd_step(date_r.month, 8'h12, 8'h01);
                if (year_end) begin
                    date_nxt.year = bcd_step(date_r.year, 8'h99, 8'h00);
                end
            end else begin
                date_nxt.day = bcd_step(date_r.day, 8'h31, 8'h01);
            end
        end
        if (wr_day) begin
            date_nxt.day = reg_req.wr_data & rtc_date_trim_pkg::mask_day; // R1 R17
        end
        if (wr_month) begin
            date_nxt.month = reg_req.wr_data & rtc_date_trim_pkg::mask_month; // R2 R17
        end
        if (wr_year) begin
            date_nxt.year = reg_req.wr_data & rtc_date_trim_pkg::mask_year; // R3
        end
    end

    // date registers; a halt leaves them as they are, their content is then undefined
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            date_r <= {rtc_date_trim_pkg::reset_day, rtc_date_trim_pkg::reset_month, rtc_date_trim_pkg::reset_year};
        end else begin
            date_r <= date_nxt;
        end
    end

    // trimming register; a set halt flag wins over a host write in the same cycle
    always_comb begin
        trim_nxt = trim_r;
        if (wr_trim) begin
            trim_nxt = reg_req.wr_data; // R5
        end
        if (osc_halt_flag) begin
            trim_nxt = rtc_date_trim_pkg::reset_trim; // R4 R15
        end
    end

    // trimming register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trim_r <= rtc_date_trim_pkg::reset_trim;
        end else begin
            trim_r <= trim_nxt;
        end
    end

    // alarm minute registers; bit 7 is dropped on write
    always_comb begin
        alarm_a_nxt = alarm_a_r;
        alarm_b_nxt = alarm_b_r;
        if (wr_alarm_a) begin
            alarm_a_nxt = reg_req.wr_data & rtc_date_trim_pkg::mask_alarm_min; // R13 R17
        end
        if (wr_alarm_b) begin
            alarm_b_nxt = reg_req.wr_data & rtc_date_trim_pkg::mask_alarm_min; // R14 R17
        end
        alarm_a_out_nxt = alarm_a_nxt;
        alarm_b_out_nxt = alarm_b_nxt;
    end

    // alarm minute registers and their output copies
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alarm_a_r <= rtc_date_trim_pkg::reset_alarm_min;
            alarm_b_r <= rtc_date_trim_pkg::reset_alarm_min;
            alarm_a_minute <= rtc_date_trim_pkg::reset_alarm_min;
            alarm_b_minute <= rtc_date_trim_pkg::reset_alarm_min;
        end else begin
            alarm_a_r <= alarm_a_nxt;
            alarm_b_r <= alarm_b_nxt;
            alarm_a_minute <= alarm_a_out_nxt;
            alarm_b_minute <= alarm_b_out_nxt;
        end
    end

    // registered read data; unmapped addresses read zero
    always_comb begin
        case (reg_req.addr)
            rtc_date_trim_pkg::addr_day: rd_data_nxt = date_r.day & rtc_date_trim_pkg::mask_day; // R1
            rtc_date_trim_pkg::addr_month: rd_data_nxt = date_r.month & rtc_date_trim_pkg::mask_month; // R2
            rtc_date_trim_pkg::addr_year: rd_data_nxt = date_r.year; // R3
            rtc_date_trim_pkg::addr_trim: rd_data_nxt = trim_r; // R4
            rtc_date_trim_pkg::addr_alarm_a_min: rd_data_nxt = alarm_a_r & rtc_date_trim_pkg::mask_alarm_min; // R12 R13
            rtc_date_trim_pkg::addr_alarm_b_min: rd_data_nxt = alarm_b_r & rtc_date_trim_pkg::mask_alarm_min; // R12 R14
            default: rd_data_nxt = 8'h00;
        endcase
    end

    // read data register; answers one cycle after the address is shown
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_data_nxt;
        end
    end
endmodule

// ---- tb/osc_model.sv ----
// partner model: oscillator pulse source and seconds value of the clock counter
module osc_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] sec_set,
    output logic osc_tick = 1'b0,
    output logic [7:0] seconds_bcd = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // one pulse every cycle once out of reset, seconds follow the bench setting
    always @(posedge ref_clk) begin
        osc_tick <= !rst;
        seconds_bcd <= sec_set;
    end
endmodule

// ---- tb/rtc_date_trim_properties.sv ----
// checker: concurrent properties on the date, trim and alarm minute block ports
module rtc_date_trim_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire rtc_date_trim_pkg::reg_req_t reg_req,
    input wire logic osc_tick,
    input wire logic osc_halt_flag,
    input wire logic [7:0] rd_data,
    input wire logic second_tick,
    input wire logic clk32_out,
    input wire logic [7:0] alarm_a_minute,
    input wire logic [7:0] alarm_b_minute
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // read data, alarm minute output, clock output and second pulse relations
    a_day_high_zero: assert property (reg_req.addr == 4'h4 |=> rd_data[7:6] == 2'b00) else $error("day high bits set");
    a_month_high_zero: assert property (reg_req.addr == 4'h5 |=> rd_data[7:5] == 3'b000) else $error("month high bits set");
    a_year_write_echo: assert property ((reg_req.wr_en && reg_req.addr == 4'h6) ##1 (!reg_req.wr_en && reg_req.addr == 4'h6)
        |=> rd_data == $past(reg_req.wr_data, 2)) else $error("year readback wrong");
    a_halt_trim_zero: assert property ((osc_halt_flag && reg_req.addr == 4'h7) [*2] |=> rd_data == 8'h00)
        else $error("trim not cleared by halt");
    a_unmapped_zero: assert property (!(reg_req.addr inside {[4'h4:4'h8], 4'hb}) |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_alarm_a_msb: assert property (alarm_a_minute[7] == 1'b0) else $error("alarm a bit7 set");
    a_alarm_b_msb: assert property (alarm_b_minute[7] == 1'b0) else $error("alarm b bit7 set");
    a_clk_out_raw: assert property (clk32_out == $past(osc_tick)) else $error("clock output not raw");
    a_tick_after_osc: assert property (second_tick |-> $past(osc_tick) && !$past(second_tick))
        else $error("second pulse without oscillator pulse");
endmodule
bind rtc_date_trim_alarm_minute rtc_date_trim_properties chk_u (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
    .osc_tick(osc_tick), .osc_halt_flag(osc_halt_flag), .rd_data(rd_data), .second_tick(second_tick),
    .clk32_out(clk32_out), .alarm_a_minute(alarm_a_minute), .alarm_b_minute(alarm_b_minute));

// ---- tb/rtc_date_trim_alarm_minute_tb.sv ----
// testbench: register map, calendar carry and trimmed second length
module rtc_date_trim_alarm_minute_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    rtc_date_trim_pkg::reg_req_t reg_req = '0;
    logic day_carry = 1'b0;
    logic osc_halt_flag = 1'b0;
    logic [7:0] sec_set = 8'h00;
    logic osc_tick, second_tick, clk32_out;
    logic [7:0] seconds_bcd, rd_data, alarm_a_minute, alarm_b_minute;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int last = 0;
    int per = 0;
    int mem [16];
    int al [5] = '{4, 5, 6, 8, 11};
    // clock, and the spacing of second pulses in cycles
    always #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        cyc++;
        if (second_tick === 1'b1) begin
            per = cyc - last;
            last = cyc;
        end
    end
    osc_model osc_u (.ref_clk(ref_clk), .rst(rst), .sec_set(sec_set), .osc_tick(osc_tick), .seconds_bcd(seconds_bcd));
    rtc_date_trim_alarm_minute dut_u (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .osc_tick(osc_tick),
        .seconds_bcd(seconds_bcd), .day_carry(day_carry), .osc_halt_flag(osc_halt_flag), .rd_data(rd_data),
        .second_tick(second_tick), .clk32_out(clk32_out), .alarm_a_minute(alarm_a_minute),
        .alarm_b_minute(alarm_b_minute));
    // writable bits of each register, zero where nothing is mapped
    function automatic int mask(int a);
        case (a)
            4: return 8'h3f;
            5: return 8'h1f;
            6, 7: return 8'hff;
            8, 11: return 8'h7f;
            default: return 0;
        endcase
    endfunction
    task chk(input logic [15:0] seen, input int exp);
        total_checks++;
        if (seen !== 16'(exp)) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input int a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_req <= '{1'b1, 4'(a), v};
        mem[a] = v & mask(a);
    endtask
    task rd(input int a);
        @(posedge ref_clk);
        reg_req <= '{1'b0, 4'(a), 8'h00};
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(rd_data, mem[a]);
    endtask
    task carry();
        @(posedge ref_clk);
        reg_req.wr_en <= 1'b0;
        day_carry <= 1'b1;
        @(posedge ref_clk);
        day_carry <= 1'b0;
    endtask
    task wt();
        for (int n = 0; n < 40000; n++) begin
            @(negedge ref_clk);
            #1;
            if (second_tick === 1'b1) break;
        end
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        void'($urandom(38190));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(al[i], 8'($urandom));
            rd(al[i]);
        end
        chk(alarm_a_minute, mem[8]);
        chk(alarm_b_minute, mem[11]);
        rd(9);
        $display("test registers done");
        wr(7, 8'hc5);
        rd(7);
        @(posedge ref_clk);
        osc_halt_flag <= 1'b1;
        repeat (3) @(posedge ref_clk);
        osc_halt_flag <= 1'b0;
        mem[7] = 0;
        rd(7);
        $display("test halt done");
        wr(6, 8'h04);
        wr(5, 8'h02);
        wr(4, 8'h28);
        carry();
        mem[4] = 8'h29;
        rd(4);
        carry();
        mem[4] = 8'h01;
        mem[5] = 8'h03;
        rd(4);
        rd(5);
        $display("test calendar done");
        wr(7, 8'h7e);
        wt();
        wt();
        chk(per, 32764);
        sec_set <= 8'h15;
        wr(7, 8'h83);
        wt();
        chk(per, 32000);
        $display("test trimming done");
        end_of_test();
    end
    // watchdog
    initial begin
        #1100000;
        n_mismatch++;
        end_of_test();
    end
endmodule
